// ===== hw/sorc_consts.svh
/*
 * Offsets, field positions, reset values and timing counts of the open-loop
 * startup ramp block.
 * Assumes a 250 MHz core clock and byte addresses on an 8-bit register port.
 */
`ifndef SORC_CONSTS_SVH
`define SORC_CONSTS_SVH

`define SORC_CFG2_OFS 8'h84
`define SORC_INIT_OFS 8'h80
`define SORC_CTRL_OFS 8'hc0
`define SORC_STAT_OFS 8'hc4
`define SORC_FREQ_LO_OFS 8'hc8
`define SORC_FREQ_HI_OFS 8'hcc

`define SORC_A1_MSB 22
`define SORC_A1_LSB 18
`define SORC_A2_MSB 17
`define SORC_A2_LSB 13
`define SORC_HO_MSB 12
`define SORC_HO_LSB 8
`define SORC_AUTO_BIT 7
`define SORC_SEL_BIT 6
`define SORC_MIN_MSB 5
`define SORC_MIN_LSB 2

`define SORC_CFG2_RESET 32'h0000_0000
`define SORC_CFG2_WMASK 32'hffff_fffc
`define SORC_INIT_RESET 4'h0

// Rate and frequency scale factors between the table units and the ramp.
`define SORC_MHZ_TO_NHZ 64'h0000_0000_000f_4240
`define SORC_MHZ_TO_UHZ 64'h0000_0000_0000_03e8
`define SORC_MHZ_TO_PHZ 64'h0000_0000_3b9a_ca00
`define SORC_HZ_TO_PHZ 64'h0000_00e8_d4a5_1000
`define SORC_ACC_MAX_MHZ 25'h1f3fc18

`define SORC_CLK_PERIOD_NS 4
`define SORC_TICK_TIME_NS 1000000
`define SORC_TICK_CYC \
    ((`SORC_TICK_TIME_NS + `SORC_CLK_PERIOD_NS - 1) / `SORC_CLK_PERIOD_NS)

`endif

// ===== hw/sorc_pkg.sv
/*
 * Types shared by the open-loop startup ramp block.
 * Assumes the constants header is compiled alongside.
 */
package sorc_pkg;

    typedef enum logic [1:0] {
        SORC_IDLE,
        SORC_RAMP,
        SORC_CLOSED
    } sorc_state_t;

    typedef struct packed {
        logic [24:0] a1_mhz;
        logic [24:0] a2_mhz;
        logic [9:0] handoff_hz;
        logic [17:0] init_mhz;
        logic [9:0] min_duty;
    } sorc_decoded_t;

    typedef struct packed {
        sorc_state_t st;
        logic [31:0] cfg2;
        logic [3:0] init_code;
        logic run;
        logic [17:0] tick_cnt;
        logic [63:0] a2t;
        logic [63:0] freq;
        logic [9:0] duty;
        logic [31:0] rdata;
        logic closed;
        logic running;
    } sorc_regs_t;

endpackage

// ===== hw/sorc_decode.sv
/*
 * Code-to-value tables for the startup ramp fields.
 * Assumes codes come straight from the configuration registers; purely
 * combinational, the caller registers what it needs.
 */
`timescale 1ns/1ps
`include "sorc_consts.svh"

module sorc_decode
    import sorc_pkg::*;
(
    input wire logic [31:0] cfg2_i,
    input wire logic [3:0] init_code_i,
    output sorc_decoded_t dec_o
);

    // Both acceleration terms share one table, in thousandths of a unit.
    function automatic logic [24:0] accel_mhz(input logic [4:0] code);
        case (code)
            5'h00: accel_mhz = 25'h5;
            5'h01: accel_mhz = 25'ha;
            5'h02: accel_mhz = 25'h19;
            5'h03: accel_mhz = 25'h32;
            5'h04: accel_mhz = 25'h64;
            5'h05: accel_mhz = 25'hfa;
            5'h06: accel_mhz = 25'h1f4;
            5'h07: accel_mhz = 25'h3e8;
            5'h08: accel_mhz = 25'h9c4;
            5'h09: accel_mhz = 25'h1388;
            5'h0a: accel_mhz = 25'h1d4c;
            5'h0b: accel_mhz = 25'h2710;
            5'h0c: accel_mhz = 25'h30d4;
            5'h0d: accel_mhz = 25'h3a98;
            5'h0e: accel_mhz = 25'h4e20;
            5'h0f: accel_mhz = 25'h7530;
            5'h10: accel_mhz = 25'h9c40;
            5'h11: accel_mhz = 25'hc350;
            5'h12: accel_mhz = 25'hea60;
            5'h13: accel_mhz = 25'h124f8;
            5'h14: accel_mhz = 25'h186a0;
            5'h15: accel_mhz = 25'h1e848;
            5'h16: accel_mhz = 25'h249f0;
            5'h17: accel_mhz = 25'h2ab98;
            5'h18: accel_mhz = 25'h30d40;
            5'h19: accel_mhz = 25'h3d090;
            5'h1a: accel_mhz = 25'h493e0;
            5'h1b: accel_mhz = 25'h61a80;
            5'h1c: accel_mhz = 25'h7a120;
            5'h1d: accel_mhz = 25'hb71b0;
            5'h1e: accel_mhz = 25'hf4240;
            default: accel_mhz = `SORC_ACC_MAX_MHZ;
        endcase
    endfunction

    function automatic logic [9:0] handoff_hz(input logic [4:0] code);
        case (code)
            5'h00: handoff_hz = 10'h1;
            5'h01: handoff_hz = 10'h4;
            5'h02: handoff_hz = 10'h8;
            5'h03: handoff_hz = 10'hc;
            5'h04: handoff_hz = 10'h10;
            5'h05: handoff_hz = 10'h14;
            5'h06: handoff_hz = 10'h18;
            5'h07: handoff_hz = 10'h1c;
            5'h08: handoff_hz = 10'h20;
            5'h09: handoff_hz = 10'h24;
            5'h0a: handoff_hz = 10'h28;
            5'h0b: handoff_hz = 10'h2d;
            5'h0c: handoff_hz = 10'h32;
            5'h0d: handoff_hz = 10'h37;
            5'h0e: handoff_hz = 10'h3c;
            5'h0f: handoff_hz = 10'h41;
            5'h10: handoff_hz = 10'h46;
            5'h11: handoff_hz = 10'h4b;
            5'h12: handoff_hz = 10'h50;
            5'h13: handoff_hz = 10'h55;
            5'h14: handoff_hz = 10'h5a;
            5'h15: handoff_hz = 10'h64;
            5'h16: handoff_hz = 10'h96;
            5'h17: handoff_hz = 10'hc8;
            5'h18: handoff_hz = 10'hfa;
            5'h19: handoff_hz = 10'h12c;
            5'h1a: handoff_hz = 10'h15e;
            5'h1b: handoff_hz = 10'h190;
            5'h1c: handoff_hz = 10'h1c2;
            5'h1d: handoff_hz = 10'h1f4;
            5'h1e: handoff_hz = 10'h226;
            default: handoff_hz = 10'h258;
        endcase
    endfunction

    // Code Ah has no printed value; it sits between its neighbours.
    function automatic logic [17:0] init_mhz(input logic [3:0] code);
        case (code)
            4'h0: init_mhz = 18'h32;
            4'h1: init_mhz = 18'h64;
            4'h2: init_mhz = 18'hfa;
            4'h3: init_mhz = 18'h1f4;
            4'h4: init_mhz = 18'h3e8;
            4'h5: init_mhz = 18'h7d0;
            4'h6: init_mhz = 18'hbb8;
            4'h7: init_mhz = 18'h1388;
            4'h8: init_mhz = 18'h2710;
            4'h9: init_mhz = 18'h3a98;
            4'ha: init_mhz = 18'h4e20;
            4'hb: init_mhz = 18'h61a8;
            4'hc: init_mhz = 18'hc350;
            4'hd: init_mhz = 18'h186a0;
            4'he: init_mhz = 18'h249f0;
            default: init_mhz = 18'h30d40;
        endcase
    endfunction

    // Duty in tenths of a percent.
    function automatic logic [9:0] min_duty(input logic [3:0] code);
        case (code)
            4'h0: min_duty = 10'hf;
            4'h1: min_duty = 10'h14;
            4'h2: min_duty = 10'h1e;
            4'h3: min_duty = 10'h28;
            4'h4: min_duty = 10'h32;
            4'h5: min_duty = 10'h3c;
            4'h6: min_duty = 10'h46;
            4'h7: min_duty = 10'h50;
            4'h8: min_duty = 10'h5a;
            4'h9: min_duty = 10'h64;
            4'ha: min_duty = 10'h78;
            4'hb: min_duty = 10'h96;
            4'hc: min_duty = 10'haf;
            4'hd: min_duty = 10'hc8;
            4'he: min_duty = 10'hfa;
            default: min_duty = 10'h12c;
        endcase
    endfunction

    always_comb
    begin
        dec_o.a1_mhz = accel_mhz(cfg2_i[`SORC_A1_MSB:`SORC_A1_LSB]);
        dec_o.a2_mhz = accel_mhz(cfg2_i[`SORC_A2_MSB:`SORC_A2_LSB]);
        dec_o.handoff_hz = handoff_hz(cfg2_i[`SORC_HO_MSB:`SORC_HO_LSB]);
        dec_o.init_mhz = init_mhz(init_code_i);
        dec_o.min_duty = min_duty(cfg2_i[`SORC_MIN_MSB:`SORC_MIN_LSB]);
    end

endmodule

// ===== hw/sorc_top.sv
/*
 * Open-loop startup ramp controller: configuration registers, ramp state
 * machine, handoff to closed loop and minimum-duty floor.
 * Assumes a 250 MHz clock, a synchronous active-high reset, a register
 * master that never waits, and a back-EMF detector that reports lock.
// Overview of operation
// - Bits 22..18 pick the linear ramp rate, 0.005 Hz/s up to 1000 Hz/s.
// - Linear code 1Fh means no limit and uses 32767 Hz/s.
// - Bits 17..13 pick the second-order term from the same table.
// - Second-order code 1Fh means unlimited and uses 32767 Hz/s2.
// - Bits 12..8 pick the handoff speed, 1 Hz, 4 Hz and upward.
// - Bit 7 low hands off at the set speed, high hands off automatically.
// - Bit 6 low starts at the slow first-cycle speed, high starts at 0 Hz.
// - Bits 5..2 pick the minimum duty, 1.5 % up to 30 %.
// - The slow first-cycle code gives 0.05 Hz at zero up to 200 Hz.
 */
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "sorc_consts.svh"

module sorc_top
    import sorc_pkg::*;
#(
    parameter int TICK_CYCLES = `SORC_TICK_CYC
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic bemf_valid_i,
    input wire logic [9:0] duty_cmd_i,
    output logic [9:0] duty_o,
    output logic [63:0] freq_o,
    output logic closed_loop_o,
    output logic running_o
);

    sorc_regs_t st;
    sorc_regs_t next_st;
    sorc_decoded_t dec;

    logic tick;
    logic [63:0] a1_rate;
    logic [63:0] rate;
    logic [63:0] rate_max;
    logic [63:0] handoff_phz;
    logic [63:0] init_phz;
    logic [63:0] a2_step;
    logic manual_hit;

    sorc_decode u_decode (
        .cfg2_i(st.cfg2),
        .init_code_i(st.init_code),
        .dec_o(dec)
    );

    assign tick = (st.tick_cnt == 18'(TICK_CYCLES - 1));
    assign rate_max = 64'(`SORC_ACC_MAX_MHZ) * `SORC_MHZ_TO_NHZ;
    // Rates run in nHz/s so that one 1 ms tick adds them as pHz.
    assign a1_rate = 64'(dec.a1_mhz) * `SORC_MHZ_TO_NHZ;
    assign a2_step = 64'(dec.a2_mhz) * `SORC_MHZ_TO_UHZ;
    assign handoff_phz = 64'(dec.handoff_hz) * `SORC_HZ_TO_PHZ;
    assign init_phz = 64'(dec.init_mhz) * `SORC_MHZ_TO_PHZ;
    assign manual_hit = (st.freq >= handoff_phz);

    always_comb
    begin
        logic [63:0] sum;
        sum = 64'h0;
        next_st = st;
        sum = a1_rate + st.a2t;
        // Clamping keeps a long ramp from wrapping the accumulators.
        if (sum > rate_max)
        begin
            rate = rate_max;
        end
        else
        begin
            rate = sum;
        end

        if (wr_i)
        begin
            if (addr_i == `SORC_CFG2_OFS)
            begin
                next_st.cfg2 = wdata_i & `SORC_CFG2_WMASK;
            end
            else if (addr_i == `SORC_INIT_OFS)
            begin
                next_st.init_code = wdata_i[3:0];
            end
            else if (addr_i == `SORC_CTRL_OFS)
            begin
                next_st.run = wdata_i[0];
            end
        end

        next_st.rdata = 32'h0;
        if (rd_i)
        begin
            if (addr_i == `SORC_CFG2_OFS)
            begin
                next_st.rdata = st.cfg2;
            end
            else if (addr_i == `SORC_INIT_OFS)
            begin
                next_st.rdata = {28'h0, st.init_code};
            end
            else if (addr_i == `SORC_CTRL_OFS)
            begin
                next_st.rdata = {31'h0, st.run};
            end
            else if (addr_i == `SORC_STAT_OFS)
            begin
                next_st.rdata = {30'h0, st.st};
            end
            else if (addr_i == `SORC_FREQ_LO_OFS)
            begin
                next_st.rdata = st.freq[31:0];
            end
            else if (addr_i == `SORC_FREQ_HI_OFS)
            begin
                next_st.rdata = st.freq[63:32];
            end
        end

        next_st.tick_cnt = tick ? 18'h0 : st.tick_cnt + 18'h1;

        case (st.st)
            SORC_IDLE:
            begin
                next_st.freq = 64'h0;
                next_st.a2t = 64'h0;
                next_st.tick_cnt = 18'h0;
                if (st.run)
                begin
                    next_st.st = SORC_RAMP;
                    next_st.freq = st.cfg2[`SORC_SEL_BIT] ? 64'h0
                                                         : init_phz;
                end
            end
            SORC_RAMP:
            begin
                if (!st.run)
                begin
                    next_st.st = SORC_IDLE;
                end
                else if (st.cfg2[`SORC_AUTO_BIT] ? bemf_valid_i
                                                 : manual_hit)
                begin
                    next_st.st = SORC_CLOSED;
                end
                else if (tick)
                begin
                    next_st.freq = st.freq + rate;
                    if (st.a2t < rate_max)
                    begin
                        next_st.a2t = st.a2t + a2_step;
                    end
                end
            end
            SORC_CLOSED:
            begin
                // Frequency is held; the closed-loop stage owns speed now.
                if (!st.run)
                begin
                    next_st.st = SORC_IDLE;
                end
            end
            default:
            begin
                next_st.st = SORC_IDLE;
            end
        endcase

        if (next_st.st == SORC_IDLE)
        begin
            next_st.duty = 10'h0;
        end
        else if (duty_cmd_i < dec.min_duty)
        begin
            next_st.duty = dec.min_duty;
        end
        else
        begin
            next_st.duty = duty_cmd_i;
        end

        // Status outputs are registered so that they change with the state.
        next_st.closed = (next_st.st == SORC_CLOSED);
        next_st.running = (next_st.st != SORC_IDLE);
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            st <= '{st: SORC_IDLE, cfg2: `SORC_CFG2_RESET,
                    init_code: `SORC_INIT_RESET, default: '0};
        end
        else if (ce_i)
        begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;
    assign duty_o = st.duty;
    assign freq_o = st.freq;
    assign closed_loop_o = st.closed;
    assign running_o = st.running;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_ramp_tick;
        ce_i && st.st == SORC_RAMP && st.run && tick;
    endsequence

    sequence s_no_handoff;
        !(st.cfg2[`SORC_AUTO_BIT] ? bemf_valid_i : manual_hit);
    endsequence

    sequence s_ramp_wait;
        ce_i && st.st == SORC_RAMP && st.run && !tick;
    endsequence

    a_a1_top_code: assert property (
        st.cfg2[`SORC_A1_MSB:`SORC_A1_LSB] == 5'h1e
        |-> a1_rate == 64'h0000_00e8_d4a5_1000)
        else $error("linear code 1Eh is not 1000 Hz/s");

    a_a1_no_limit: assert property (
        st.cfg2[`SORC_A1_MSB:`SORC_A1_LSB] == 5'h1f |-> rate == rate_max)
        else $error("linear code 1Fh does not give the maximum rate");

    a_a2_low_code: assert property (
        st.cfg2[`SORC_A2_MSB:`SORC_A2_LSB] == 5'h0 |-> a2_step == 64'h1388)
        else $error("second-order code 0 is not 0.005 Hz/s2");

    a_a2_no_limit: assert property (
        st.cfg2[`SORC_A2_MSB:`SORC_A2_LSB] == 5'h1f
        |-> dec.a2_mhz == 25'h1f3fc18)
        else $error("second-order code 1Fh is not 32767");

    a_handoff_code: assert property (
        st.cfg2[`SORC_HO_MSB:`SORC_HO_LSB] == 5'h1
        |-> handoff_phz == 64'h0000_03a3_5294_4000)
        else $error("handoff code 1h is not 4 Hz");

    a_manual_handoff: assert property (
        ce_i && st.st == SORC_RAMP && st.run && !st.cfg2[`SORC_AUTO_BIT]
        && manual_hit |=> st.st == SORC_CLOSED)
        else $error("manual handoff missed at the set speed");

    a_auto_waits: assert property (
        ce_i && st.st == SORC_RAMP && st.cfg2[`SORC_AUTO_BIT]
        && !bemf_valid_i |=> st.st != SORC_CLOSED)
        else $error("automatic handoff without back-EMF lock");

    a_first_cycle: assert property (
        ce_i && st.st == SORC_IDLE && st.run
        |=> freq_o == ($past(st.cfg2[`SORC_SEL_BIT]) ? 64'h0
                                                     : $past(init_phz)))
        else $error("first cycle started at the wrong frequency");

    a_min_duty_top: assert property (
        st.cfg2[`SORC_MIN_MSB:`SORC_MIN_LSB] == 4'hf
        |-> dec.min_duty == 10'h12c)
        else $error("minimum duty code Fh is not 30 percent");

    a_init_top: assert property (
        st.init_code == 4'hf |-> init_phz == 64'h0000_b5e6_20f4_8000)
        else $error("first-cycle code Fh is not 200 Hz");

    a_ramp_step: assert property (
        s_ramp_tick ##0 s_no_handoff
        |=> freq_o == $past(st.freq) + $past(rate) ##1 !tick)
        else $error("ramp step differs from the summed rate");

    a_duty_floor: assert property (
        ce_i && next_st.st != SORC_IDLE |=> duty_o >= $past(dec.min_duty))
        else $error("applied duty fell below the minimum");

    a_a1_low_code: assert property (
        st.cfg2[`SORC_A1_MSB:`SORC_A1_LSB] == 5'h0
        |-> a1_rate == 64'h0000_0000_004c_4b40)
        else $error("linear code 0 is not 0.005 Hz/s");

    a_handoff_low: assert property (
        st.cfg2[`SORC_HO_MSB:`SORC_HO_LSB] == 5'h0
        |-> handoff_phz == 64'h0000_00e8_d4a5_1000)
        else $error("handoff code 0 is not 1 Hz");

    a_init_low: assert property (
        st.init_code == 4'h0 |-> init_phz == 64'h0000_000b_a43b_7400)
        else $error("first-cycle code 0 is not 0.05 Hz");

    a_min_duty_low: assert property (
        st.cfg2[`SORC_MIN_MSB:`SORC_MIN_LSB] == 4'h0
        |-> dec.min_duty == 10'hf)
        else $error("minimum duty code 0 is not 1.5 percent");

    a_auto_takes: assert property (
        ce_i && st.st == SORC_RAMP && st.run && st.cfg2[`SORC_AUTO_BIT]
        && bemf_valid_i |=> st.st == SORC_CLOSED)
        else $error("automatic handoff missed on back-EMF lock");

    a_ramp_holds: assert property (
        s_ramp_wait ##0 s_no_handoff |=> freq_o == $past(st.freq))
        else $error("frequency moved between ramp ticks");

    a_closed_holds: assert property (
        ce_i && st.st == SORC_CLOSED && st.run
        |=> freq_o == $past(st.freq))
        else $error("frequency moved after the handoff");

endmodule

// ===== tb/sorc_motor_model.sv
/*
 * Behavioural stand-in for the spinning motor and its back-EMF sensing.
 * Assumes the startup controller's frequency and running outputs; lock is
 * reported only after the speed has stayed above a set level for lag cycles.
 */
`timescale 1ns/1ps

module sorc_motor_model #(
    parameter logic [63:0] LOCK_PHZ = 64'h0000_02ba_7def_3000
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic running_i,
    input wire logic [63:0] freq_i,
    input wire logic [7:0] lag_i,
    output logic bemf_valid_o
);
    logic [7:0] cnt;

    // A motor that is slowed or stopped loses its back-EMF at once.
    always_ff @(posedge clk_i)
    begin
        if (reset_i || !running_i || freq_i < LOCK_PHZ)
        begin
            cnt <= 8'h00;
            bemf_valid_o <= 1'b0;
        end
        else if (cnt < lag_i)
        begin
            cnt <= cnt + 8'h01;
        end
        else
        begin
            bemf_valid_o <= 1'b1;
        end
    end
endmodule

// ===== tb/tb.sv
/*
 * Self-checking bench of the open-loop startup ramp controller.
 * Assumes the design files and the constants header are compiled first.
 */
`timescale 1ns/1ps
`include "sorc_consts.svh"

module tb;
    localparam int TC = 8;
    localparam longint unsigned CAP = 64'd32767000000000;
    localparam int unsigned ACC [32] = '{5, 10, 25, 50, 100, 250, 500, 1000,
        2500, 5000, 7500, 10000, 12500, 15000, 20000, 30000, 40000, 50000,
        60000, 75000, 100000, 125000, 150000, 175000, 200000, 250000, 300000,
        400000, 500000, 750000, 1000000, 32767000};
    localparam int unsigned HO [7] = '{1, 4, 8, 12, 16, 20, 24};
    localparam int unsigned INI [16] = '{50, 100, 250, 500, 1000, 2000, 3000,
        5000, 10000, 15000, 20000, 25000, 50000, 100000, 150000, 200000};
    localparam int unsigned MIN [16] = '{15, 20, 30, 40, 50, 60, 70, 80, 90,
        100, 120, 150, 175, 200, 250, 300};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic dgen = 1'b0;
    logic bemf, closed, running, pclosed, pend, prun, pb;
    logic [7:0] addr = 8'h00;
    logic [7:0] lag = 8'h01;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata, rv, d;
    logic [9:0] duty_cmd = 10'h000;
    logic [9:0] duty, pcmd;
    logic [63:0] freq, i1, i2;
    logic [63:0] thr = 64'h0;
    logic [3:0] min_code = 4'h0;
    logic [7:0] addrs [7];
    int n_fail = 0;
    int tests_run = 0;
    int hmode = 0;
    int ho;

    always #2 clk = ~clk;

    sorc_top #(.TICK_CYCLES(TC)) DUT (.clk_i(clk), .reset_i(reset),
        .ce_i(ce), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .bemf_valid_i(bemf), .duty_cmd_i(duty_cmd),
        .duty_o(duty), .freq_o(freq), .closed_loop_o(closed),
        .running_o(running));

    sorc_motor_model motor (.clk_i(clk), .reset_i(reset),
        .running_i(running), .freq_i(freq), .lag_i(lag),
        .bemf_valid_o(bemf));

    task automatic err(string m);
        n_fail++;
        $display("ERROR t=%0t %s", $time, m);
    endtask

    task automatic chk(logic [63:0] g, logic [63:0] e, string m);
        tests_run++;
        if (g !== e) err(m);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wr_reg(logic [7:0] a, logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    function automatic logic [31:0] cfg(int a1, int a2, int h, int au,
        int sel);
        return {9'h000, 5'(a1), 5'(a2), 5'(h), 1'(au), 1'(sel), min_code,
            2'b00};
    endfunction

    function automatic longint unsigned rate(int i, int j, int k);
        longint unsigned r;
        r = 64'(ACC[i]) * 1000000 + 64'(ACC[j]) * 1000 * k;
        return (r > CAP) ? CAP : r;
    endfunction

    task automatic start(logic [31:0] c);
        int k;
        wr_reg(`SORC_CFG2_OFS, c);
        wr_reg(`SORC_CTRL_OFS, 32'h1);
        for (k = 0; k < 8 && running !== 1'b1; k++) @(negedge clk);
        chk(running, 1'b1, "ramp not entered");
    endtask

    task automatic stop();
        wr_reg(`SORC_CTRL_OFS, 32'h0);
        // The frequency clears one cycle after the state returns to idle.
        repeat (3) @(negedge clk);
        chk({closed, running}, 2'b00, "not back to idle");
        chk(freq, 64'h0, "frequency not cleared");
    endtask

    task automatic wait_step(output logic [63:0] inc);
        logic [63:0] f0;
        int k;
        @(negedge clk);
        f0 = freq;
        for (k = 0; k < 4 * TC && freq === f0; k++) @(negedge clk);
        if (freq === f0) err("no ramp step");
        inc = freq - f0;
    endtask

    task automatic wait_closed();
        int k;
        for (k = 0; k < 8000 && closed !== 1'b1; k++) @(negedge clk);
        chk(closed, 1'b1, "no handoff");
    endtask

    always @(posedge clk)
    begin
        if (dgen) duty_cmd <= 10'($urandom_range(1000, 0));
    end

    // Handoff and duty floor are watched on every cycle of every scenario.
    always @(negedge clk)
    begin
        if (!reset)
        begin
            if (pend && !closed) err("handoff late");
            if (closed && !pclosed && hmode == 1 && freq < thr)
                err("handoff below speed");
            if (closed && !pclosed && hmode == 2 && !pb)
                err("handoff without lock");
            if (prun && running)
                chk(duty, (pcmd > MIN[min_code]) ? pcmd : 10'(MIN[min_code]),
                    "duty floor");
            if (!prun && !running) chk(duty, 10'h0, "idle duty");
        end
        pend = running && !closed && (hmode == 1 ? freq >= thr :
            hmode == 2 && bemf);
        pclosed = closed;
        prun = running;
        pcmd = duty_cmd;
        pb = bemf;
    end

    initial
    begin
        #(4 * 60000);
        err("watchdog expired");
        summarize();
    end

    initial
    begin
        rv = $urandom(54587);
        addrs = '{`SORC_CFG2_OFS, `SORC_INIT_OFS, `SORC_CTRL_OFS,
            `SORC_STAT_OFS, `SORC_FREQ_LO_OFS, `SORC_FREQ_HI_OFS, 8'h10};
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        dgen <= 1'b1;
        foreach (addrs[i])
        begin
            rd_reg(addrs[i], rv);
            chk(rv, 32'h0, "reset value");
        end
        d = $urandom;
        wr_reg(`SORC_CFG2_OFS, d);
        rd_reg(`SORC_CFG2_OFS, rv);
        chk(rv, d & `SORC_CFG2_WMASK, "config readback");
        wr_reg(`SORC_INIT_OFS, d);
        rd_reg(`SORC_INIT_OFS, rv);
        chk(rv, {28'h0, d[3:0]}, "first-cycle readback");
        wr_reg(8'h10, d);
        rd_reg(8'h10, rv);
        chk(rv, 32'h0, "unmapped read");
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(`SORC_CFG2_OFS, ~d);
        @(posedge clk);
        ce <= 1'b1;
        rd_reg(`SORC_CFG2_OFS, rv);
        chk(rv, d & `SORC_CFG2_WMASK, "write with clock enable low");
        hmode = 1;
        thr = 64'd600000000000000;
        for (int i = 0; i < 16; i++)
        begin
            min_code = 4'($urandom);
            wr_reg(`SORC_INIT_OFS, 32'(i));
            start(cfg(31, 0, 31, 0, 0));
            chk(freq, 64'(INI[i]) * 64'd1000000000, "start speed");
            stop();
        end
        for (int i = 0; i < 32; i++)
        begin
            start(cfg(i, 31 - i, 31, 0, 1));
            chk(freq, 64'h0, "zero start");
            wait_step(i1);
            wait_step(i2);
            chk((i1 == rate(i, 31 - i, 0) && i2 == rate(i, 31 - i, 1)) ||
                (i1 == rate(i, 31 - i, 1) && i2 == rate(i, 31 - i, 2)),
                1'b1, "ramp rate");
            stop();
        end
        for (int n = 0; n < 3; n++)
        begin
            ho = (n == 0) ? 0 : $urandom_range(6, 1);
            min_code = 4'($urandom);
            thr = 64'(HO[ho]) * 64'd1000000000000;
            start(cfg(31, $urandom_range(30, 0), ho, 0, 1));
            rd_reg(`SORC_STAT_OFS, rv);
            chk(rv, 32'h1, "ramp status");
            wait_closed();
            rd_reg(`SORC_STAT_OFS, rv);
            chk(rv, 32'h2, "closed status");
            stop();
        end
        hmode = 2;
        lag = 8'($urandom_range(20, 1));
        start(cfg(31, 0, 0, 1, 1));
        wait_closed();
        chk(freq >= 64'd3000000000000, 1'b1, "auto handoff too early");
        stop();
        summarize();
    end
endmodule
